//--- rtl/mbs_consts.svh
// register offsets, command codes, reset values and field positions for the sync role block
`ifndef MBS_CONSTS_SVH
`define MBS_CONSTS_SVH
`define MBS_OFF_CMD 20'h00000
`define MBS_OFF_PRIV 20'h30D68
`define MBS_OFF_STATUS 20'h00010
`define MBS_CMD_TRIG_MASTER 32'h00000065
`define MBS_CMD_TRIG_SLAVE 32'h0000006F
`define MBS_CMD_CLK_MASTER 32'h00000064
`define MBS_CMD_CLK_SLAVE 32'h0000006E
`define MBS_CMD_ARM_ALL 32'h00000082
`define MBS_CMD_GO 32'h0000000A
`define MBS_CMD_GO_BLOCKING 32'h0000000B
`define MBS_ST_TRIG_ROLE_LSB 0
`define MBS_ST_CLK_ROLE_LSB 2
`define MBS_ST_ARMED_BIT 4
`define MBS_ST_RUN_BIT 5
`define MBS_ST_BLOCKING_BIT 6
`define MBS_ST_PRIV_BIT 7
`define MBS_ST_OR_OK_BIT 8
`define MBS_RST_CMD 32'h00000000
`define MBS_RST_PRIV 1'b0
`endif

//--- rtl/mbs_pkg.sv
// types shared by the sync role block
package mbs_pkg;
  typedef enum logic [1:0] {TRIG_NONE, TRIG_MASTER, TRIG_SLAVE} mbs_trig_role_t;
  typedef enum logic [1:0] {CLK_NONE, CLK_MASTER, CLK_SLAVE} mbs_clk_role_t;
  typedef struct packed {
    logic trig_out;
    logic trig_out_en;
    logic clk_out_en;
    logic arm_out;
    logic arm_out_en;
  } mbs_sync_drive_t;
  typedef struct packed {
    logic trig_in;
    logic arm_in;
  } mbs_sync_sense_t;
endpackage

//--- rtl/mbs_sync_roles.sv
// sync role command interpreter with ahb-lite register slave
// Function
// R1 - code 101 makes board trigger master
// R2 - host assigns at least one trigger master
// R3 - hub ORs triggers of all masters
// R4 - no OR on cascade or old hub
// R5 - OR masters share one trigger mode
// R6 - OR needs hub board as master
// R7 - code 111 makes board trigger slave
// R8 - host gives every board a trigger role
// R9 - exclusion register selects local trigger only
// R10 - slave command precedes exclusion setting
// R11 - excluded boards may differ in mode
// R12 - code 100 makes board clock master
// R13 - host allows exactly one clock master
// R14 - code 110 makes board clock slave
// R15 - code 130 on master arms all
// R16 - start slaves first with 10 or 11
// R17 - then start all trigger masters
// R18 - hub board started last under OR
// R19 - roles hold; unknown codes ignored
//
// The AHB-Lite slave port was decided locally.
`include "mbs_consts.svh"
module mbs_sync_roles #(
  parameter int HUB_PORTS = 16
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic LOCAL_TRIG,
  input wire logic HUB_PRESENT,
  input wire logic HUB_OR_CAPABLE,
  input wire logic [HUB_PORTS-1:0] HUB_TRIG_IN,
  output logic HUB_TRIG_OUT,
  input wire mbs_pkg::mbs_sync_sense_t SYNC_IN,
  output mbs_pkg::mbs_sync_drive_t SYNC_OUT,
  output logic USE_SYNC_CLK,
  output logic ACQ_START,
  input wire logic ACQ_DONE
);
  import mbs_pkg::*;

  // bus address phase capture
  logic wr_pend_ff, nxt_wr_pend;
  logic [19:0] addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic addr_ok;
  // role, arm and run state
  mbs_trig_role_t trig_role_ff, nxt_trig_role;
  mbs_clk_role_t clk_role_ff, nxt_clk_role;
  logic priv_ff, nxt_priv;
  logic armed_ff, nxt_armed;
  logic run_ff, nxt_run;
  logic blocking_ff, nxt_blocking;
  logic [31:0] cmd_ff, nxt_cmd;
  logic arm_pulse_ff, nxt_arm_pulse;
  // three-stage samplers for the shared sync pins, the hub ports and the local trigger pin
  logic [2:0] trig_sy_ff, arm_sy_ff, loc_sy_ff;
  logic [2:0] nxt_trig_sy, nxt_arm_sy, nxt_loc_sy;
  logic trig_lvl_ff, arm_lvl_ff, loc_lvl_ff;
  logic nxt_trig_lvl, nxt_arm_lvl, nxt_loc_lvl;
  logic [HUB_PORTS-1:0] hub_s1_ff, hub_s2_ff, nxt_hub_s1, nxt_hub_s2;
  logic [HUB_PORTS-1:0] hub_s3_ff, hub_lvl_ff, nxt_hub_s3, nxt_hub_lvl;
  logic hub_or_ok;
  logic trig_event;
  logic wr_cmd;

  function automatic logic known_addr(input logic [19:0] a);
    known_addr = (a == `MBS_OFF_CMD) || (a == `MBS_OFF_PRIV) || (a == `MBS_OFF_STATUS);
  endfunction

  assign addr_ok = known_addr(addr_ff);
  assign wr_cmd = wr_pend_ff && (addr_ff == `MBS_OFF_CMD);

  // address phase registers; slave answers with zero wait states
  always_comb begin
    nxt_wr_pend = 1'b0;
    nxt_addr = addr_ff;
    if (HSEL && HREADY && HTRANS[1]) begin
      nxt_wr_pend = HWRITE;
      nxt_addr = HADDR[19:0];
    end
  end

  // read data is built in the address phase so it stands registered in the data phase
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (HADDR[19:0])
        `MBS_OFF_CMD: nxt_rdata = cmd_ff;
        `MBS_OFF_PRIV: nxt_rdata = {31'h00000000, priv_ff};
        `MBS_OFF_STATUS: begin
          nxt_rdata[`MBS_ST_TRIG_ROLE_LSB +: 2] = trig_role_ff;
          nxt_rdata[`MBS_ST_CLK_ROLE_LSB +: 2] = clk_role_ff;
          nxt_rdata[`MBS_ST_ARMED_BIT] = armed_ff;
          nxt_rdata[`MBS_ST_RUN_BIT] = run_ff;
          nxt_rdata[`MBS_ST_BLOCKING_BIT] = blocking_ff;
          nxt_rdata[`MBS_ST_PRIV_BIT] = priv_ff;
          nxt_rdata[`MBS_ST_OR_OK_BIT] = hub_or_ok;
        end
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // pin samplers: a level changes once the second and third stage agree
  always_comb begin
    nxt_trig_sy = {trig_sy_ff[1:0], SYNC_IN.trig_in};
    nxt_arm_sy = {arm_sy_ff[1:0], SYNC_IN.arm_in};
    nxt_loc_sy = {loc_sy_ff[1:0], LOCAL_TRIG};
    nxt_trig_lvl = (trig_sy_ff[1] == trig_sy_ff[2]) ? trig_sy_ff[2] : trig_lvl_ff;
    nxt_arm_lvl = (arm_sy_ff[1] == arm_sy_ff[2]) ? arm_sy_ff[2] : arm_lvl_ff;
    nxt_loc_lvl = (loc_sy_ff[1] == loc_sy_ff[2]) ? loc_sy_ff[2] : loc_lvl_ff;
    nxt_hub_s1 = HUB_TRIG_IN;
    nxt_hub_s2 = hub_s1_ff;
    nxt_hub_s3 = hub_s2_ff;
    // per port: a cable glitch seen by one stage only never reaches the hub output
    nxt_hub_lvl = (hub_s2_ff & hub_s3_ff) | (hub_lvl_ff & (hub_s2_ff | hub_s3_ff));
  end

  // R4 no OR on cascade or pre-V4 hubs
  assign hub_or_ok = HUB_PRESENT && HUB_OR_CAPABLE;
  // R3 hub ORs master triggers; without OR only the first port is passed
  assign HUB_TRIG_OUT = hub_or_ok ? (|hub_lvl_ff) : hub_lvl_ff[0];

  // role and run decode from command writes
  always_comb begin
    nxt_trig_role = trig_role_ff;
    nxt_clk_role = clk_role_ff;
    nxt_priv = priv_ff;
    nxt_armed = armed_ff;
    nxt_run = run_ff;
    nxt_blocking = blocking_ff;
    nxt_cmd = cmd_ff;
    nxt_arm_pulse = 1'b0;
    // a finished acquisition drops run and the armed state
    if (run_ff && ACQ_DONE) begin
      nxt_run = 1'b0;
      nxt_blocking = 1'b0;
      nxt_armed = 1'b0;
    end
    // arm from the clock master's shared arm line
    if (clk_role_ff == CLK_SLAVE && arm_lvl_ff) begin
      nxt_armed = 1'b1;
    end
    if (wr_pend_ff && addr_ff == `MBS_OFF_PRIV) begin
      // R9 exclusion bit stored
      nxt_priv = HWDATA[0];
    end
    if (wr_cmd) begin
      nxt_cmd = HWDATA;
      // R19 unknown codes leave roles untouched
      case (HWDATA)
        // R1 trigger master command
        `MBS_CMD_TRIG_MASTER: nxt_trig_role = TRIG_MASTER;
        // R7 trigger slave command
        `MBS_CMD_TRIG_SLAVE: nxt_trig_role = TRIG_SLAVE;
        // R12 clock master command
        `MBS_CMD_CLK_MASTER: nxt_clk_role = CLK_MASTER;
        // R14 clock slave command
        `MBS_CMD_CLK_SLAVE: nxt_clk_role = CLK_SLAVE;
        `MBS_CMD_ARM_ALL: begin
          // R15 arm only honoured on the clock master
          if (clk_role_ff == CLK_MASTER) begin
            nxt_armed = 1'b1;
            nxt_arm_pulse = 1'b1;
          end
        end
        `MBS_CMD_GO, `MBS_CMD_GO_BLOCKING: begin
          // start only once armed when the board has a clock role
          if (armed_ff || clk_role_ff == CLK_NONE) begin
            nxt_run = 1'b1;
            nxt_blocking = (HWDATA == `MBS_CMD_GO_BLOCKING);
          end
        end
        default: nxt_cmd = HWDATA;
      endcase
    end
  end

  // R9 excluded boards use only their own trigger, still clock synced
  assign trig_event = run_ff && ((trig_role_ff == TRIG_SLAVE && !priv_ff) ?
                      trig_lvl_ff : loc_lvl_ff);
  assign ACQ_START = trig_event;

  // pin drives; enables high while this board drives the line
  always_comb begin
    SYNC_OUT = '0;
    // R1 master drives its detected trigger onto the shared line
    SYNC_OUT.trig_out_en = (trig_role_ff == TRIG_MASTER);
    SYNC_OUT.trig_out = (trig_role_ff == TRIG_MASTER) && run_ff && loc_lvl_ff;
    // R12 clock master supplies the common clock
    SYNC_OUT.clk_out_en = (clk_role_ff == CLK_MASTER);
    SYNC_OUT.arm_out_en = (clk_role_ff == CLK_MASTER);
    SYNC_OUT.arm_out = arm_pulse_ff;
  end
  // R14 slaves run from the master's clock
  assign USE_SYNC_CLK = (clk_role_ff == CLK_SLAVE);

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = addr_ok ? rdata_ff : 32'h00000000;

  // state registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 20'h00000;
      rdata_ff <= 32'h00000000;
      trig_role_ff <= TRIG_NONE;
      clk_role_ff <= CLK_NONE;
      priv_ff <= `MBS_RST_PRIV;
      armed_ff <= 1'b0;
      run_ff <= 1'b0;
      blocking_ff <= 1'b0;
      cmd_ff <= `MBS_RST_CMD;
      arm_pulse_ff <= 1'b0;
      trig_sy_ff <= 3'h0;
      arm_sy_ff <= 3'h0;
      loc_sy_ff <= 3'h0;
      trig_lvl_ff <= 1'b0;
      arm_lvl_ff <= 1'b0;
      loc_lvl_ff <= 1'b0;
      hub_s1_ff <= '0;
      hub_s2_ff <= '0;
      hub_s3_ff <= '0;
      hub_lvl_ff <= '0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
      trig_role_ff <= nxt_trig_role;
      clk_role_ff <= nxt_clk_role;
      priv_ff <= nxt_priv;
      armed_ff <= nxt_armed;
      run_ff <= nxt_run;
      blocking_ff <= nxt_blocking;
      cmd_ff <= nxt_cmd;
      arm_pulse_ff <= nxt_arm_pulse;
      trig_sy_ff <= nxt_trig_sy;
      arm_sy_ff <= nxt_arm_sy;
      loc_sy_ff <= nxt_loc_sy;
      trig_lvl_ff <= nxt_trig_lvl;
      arm_lvl_ff <= nxt_arm_lvl;
      loc_lvl_ff <= nxt_loc_lvl;
      hub_s1_ff <= nxt_hub_s1;
      hub_s2_ff <= nxt_hub_s2;
      hub_s3_ff <= nxt_hub_s3;
      hub_lvl_ff <= nxt_hub_lvl;
    end
  end

  property p_trig_master;  // R1
    @(posedge CLK) disable iff (!RST_B)
      (wr_cmd && HWDATA == `MBS_CMD_TRIG_MASTER) |=> SYNC_OUT.trig_out_en;
  endproperty
  a_trig_master: assert property (p_trig_master) else $error("trigger master role not taken");

  property p_hub_or;  // R3
    @(posedge CLK) disable iff (!RST_B)
      (hub_or_ok && |hub_lvl_ff) |-> HUB_TRIG_OUT;
  endproperty
  a_hub_or: assert property (p_hub_or) else $error("hub trigger OR missing");

  property p_no_or;  // R4
    @(posedge CLK) disable iff (!RST_B)
      (!hub_or_ok && !hub_lvl_ff[0] && |hub_lvl_ff) |-> !HUB_TRIG_OUT;
  endproperty
  a_no_or: assert property (p_no_or) else $error("trigger OR used where unsupported");

  property p_trig_slave;  // R7
    @(posedge CLK) disable iff (!RST_B)
      (wr_cmd && HWDATA == `MBS_CMD_TRIG_SLAVE) |=> !SYNC_OUT.trig_out_en;
  endproperty
  a_trig_slave: assert property (p_trig_slave) else $error("trigger slave still drives line");

  property p_private;  // R9
    @(posedge CLK) disable iff (!RST_B)
      (priv_ff && run_ff && !loc_lvl_ff) |-> !ACQ_START;
  endproperty
  a_private: assert property (p_private) else $error("excluded board used shared trigger");

  property p_clk_master;  // R12
    @(posedge CLK) disable iff (!RST_B)
      (wr_cmd && HWDATA == `MBS_CMD_CLK_MASTER) |=> SYNC_OUT.clk_out_en && !USE_SYNC_CLK;
  endproperty
  a_clk_master: assert property (p_clk_master) else $error("clock master role not taken");

  property p_clk_slave;  // R14
    @(posedge CLK) disable iff (!RST_B)
      (wr_cmd && HWDATA == `MBS_CMD_CLK_SLAVE) |=> USE_SYNC_CLK && !SYNC_OUT.clk_out_en;
  endproperty
  a_clk_slave: assert property (p_clk_slave) else $error("clock slave role not taken");

  property p_arm;  // R15
    @(posedge CLK) disable iff (!RST_B)
      (wr_cmd && HWDATA == `MBS_CMD_ARM_ALL) |=>
      (SYNC_OUT.arm_out == $past(clk_role_ff == CLK_MASTER)) ##1 !SYNC_OUT.arm_out;
  endproperty
  a_arm: assert property (p_arm) else $error("arm pulse wrong");

  property p_hold;  // R19
    @(posedge CLK) disable iff (!RST_B)
      (!wr_cmd) |=> $stable(trig_role_ff) && $stable(clk_role_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("role changed without command");
endmodule

//--- tb/mbs_far_model.sv
// model of the other synchronized boards on the shared lines and hub ports
module mbs_far_model #(
  parameter int HUB_PORTS = 16
) (
  input wire mbs_pkg::mbs_sync_drive_t drv,
  input wire logic remote_trig,
  input wire logic remote_arm,
  input wire logic [HUB_PORTS-1:0] port_trig,
  output mbs_pkg::mbs_sync_sense_t sense,
  output logic [HUB_PORTS-1:0] hub_trig
);
  import mbs_pkg::*;
  // shared lines have pull-downs, so a released line reads low; only the trigger line is wired-or
  // a remote trigger master joins this board's drive
  assign sense.trig_in = remote_trig | (drv.trig_out & drv.trig_out_en);
  // a remote clock master drives this board's arm input whenever it is not the clock master
  assign sense.arm_in = (remote_arm & ~drv.arm_out_en) | (drv.arm_out & drv.arm_out_en);
  // trigger detects of the boards cabled to the hub ports
  assign hub_trig = port_trig;
endmodule

//--- tb/tb_top.sv
// self-checking bench for the sync role block
`include "mbs_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mbs_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, local_trig = 1'b0;
  logic hub_present = 1'b0, hub_or_ok = 1'b0, acq_done = 1'b0;
  logic remote_trig = 1'b0, remote_arm = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, hub_trig_out, use_sync_clk, acq_start;
  logic [15:0] port_trig = 16'h0, hub_trig;
  mbs_sync_sense_t sync_in;
  mbs_sync_drive_t sync_out;
  int miscompares = 0, cmp_count = 0;

  // clock at 125 MHz
  always #4 clk = ~clk;

  mbs_sync_roles #(.HUB_PORTS(16)) i_dut (.CLK(clk), .RST_B(rst_b), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .LOCAL_TRIG(local_trig), .HUB_PRESENT(hub_present), .HUB_OR_CAPABLE(hub_or_ok),
    .HUB_TRIG_IN(hub_trig), .HUB_TRIG_OUT(hub_trig_out), .SYNC_IN(sync_in),
    .SYNC_OUT(sync_out), .USE_SYNC_CLK(use_sync_clk), .ACQ_START(acq_start),
    .ACQ_DONE(acq_done));

  mbs_far_model #(.HUB_PORTS(16)) i_far (.drv(sync_out), .remote_trig(remote_trig),
    .remote_arm(remote_arm), .port_trig(port_trig), .sense(sync_in), .hub_trig(hub_trig));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one ahb-lite single transfer; no wait count is assumed, only a bound
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    rv = hrdata;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  // inputs cross three-flop samplers, so give them six edges
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, `MBS_OFF_STATUS, 32'h0);
    chk(rv & m, e);
  endtask

  task automatic done_pulse;
    acq_done <= 1'b1;
    @(posedge clk);
    acq_done <= 1'b0;
    settle;
  endtask

  task automatic t_reset;
    xfer(1'b0, `MBS_OFF_CMD, 32'h0);
    chk(rv, `MBS_RST_CMD);
    xfer(1'b0, `MBS_OFF_PRIV, 32'h0);
    chk(rv, 32'h0);
    xfer(1'b0, 32'h00000100, 32'h0);
    chk({rv[30:0], hresp}, 32'h0);
    st(32'h1FF, 32'h0);
  endtask

  task automatic t_trig_master;
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_TRIG_MASTER);
    settle;
    chk(sync_out.trig_out_en, 1'b1);
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_GO);
    local_trig <= 1'b1;
    settle;
    chk(sync_out.trig_out, 1'b1);
    local_trig <= 1'b0;
    hub_or_ok <= 1'b1;
    port_trig <= 16'h0008;
    settle;
    chk(hub_trig_out, 1'b0);
    hub_present <= 1'b1;
    settle;
    chk(hub_trig_out, 1'b1);
    hub_or_ok <= 1'b0;
    settle;
    chk(hub_trig_out, 1'b0);
    port_trig <= 16'h0001;
    settle;
    chk(hub_trig_out, 1'b1);
    port_trig <= 16'h0;
    hub_present <= 1'b0;
    done_pulse;
  endtask

  task automatic t_slave;
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_TRIG_SLAVE);
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_CLK_SLAVE);
    settle;
    chk({sync_out.trig_out_en, sync_out.clk_out_en, use_sync_clk}, 3'h1);
    st(32'hF, 32'hA);
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_ARM_ALL);
    st(32'h10, 32'h0);
    remote_arm <= 1'b1;
    settle;
    remote_arm <= 1'b0;
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_GO);
    st(32'h30, 32'h30);
    remote_trig <= 1'b1;
    settle;
    chk(acq_start, 1'b1);
    done_pulse;
    st(32'h30, 32'h0);
    xfer(1'b1, `MBS_OFF_PRIV, 32'h1);
    xfer(1'b0, `MBS_OFF_PRIV, 32'h0);
    chk(rv, 32'h1);
    remote_arm <= 1'b1;
    settle;
    remote_arm <= 1'b0;
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_GO_BLOCKING);
    st(32'hE0, 32'hE0);
    chk(acq_start, 1'b0);
    local_trig <= 1'b1;
    settle;
    chk(acq_start, 1'b1);
    local_trig <= 1'b0;
    remote_trig <= 1'b0;
    done_pulse;
    xfer(1'b1, `MBS_OFF_PRIV, 32'h0);
    xfer(1'b1, `MBS_OFF_CMD, 32'h0000004D);
    xfer(1'b0, `MBS_OFF_CMD, 32'h0);
    chk(rv, 32'h0000004D);
    st(32'hF, 32'hA);
  endtask

  task automatic t_clk_master;
    int n;
    n = 0;
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_CLK_MASTER);
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_GO);
    settle;
    chk({sync_out.clk_out_en, sync_out.arm_out_en, use_sync_clk}, 3'h6);
    st(32'h2F, 32'h6);
    xfer(1'b1, `MBS_OFF_CMD, `MBS_CMD_ARM_ALL);
    repeat (10) begin
      @(posedge clk);
      n += int'(sync_out.arm_out);
    end
    chk(32'(n), 32'h1);
    st(32'h1F, 32'h16);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence after five cycles of reset
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_trig_master;
    t_slave;
    t_clk_master;
    complete_run;
  end

  // watchdog far beyond the roughly 160 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run;
  end
endmodule
